// ===== tpt_pkg.sv
// Package: register map, field positions and interval tables for touch timing
package tpt_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] DETECT_TIMING_OFS = 8'h04;
  localparam logic [7:0] SETTLE_BIAS_OFS = 8'h05;
  localparam logic [7:0] DETECT_TIMING_RST = 8'h00;
  localparam logic [7:0] SETTLE_BIAS_RST = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int DET_DIS_BIT = 7;
  localparam int PRE_LSB = 4;
  localparam int SENSE_LSB = 0;
  localparam int BIAS_LSB = 6;
  localparam int SAMPLE_DBL_BIT = 5;
  localparam int SETTLE_LSB = 0;

  // ----------------------------------------
  // Interval lengths in timebase ticks (8 ticks per microsecond)
  // ----------------------------------------
  localparam int TICKS_PER_US = 8;
  localparam logic [12:0] T_0U25 = 13'h0002;
  localparam logic [12:0] T_1U = 13'(1 * TICKS_PER_US);
  localparam logic [12:0] T_2U = 13'(2 * TICKS_PER_US);
  localparam logic [12:0] T_3U = 13'(3 * TICKS_PER_US);
  localparam logic [12:0] T_10U = 13'(10 * TICKS_PER_US);
  localparam logic [12:0] T_30U = 13'(30 * TICKS_PER_US);
  localparam logic [12:0] T_100U = 13'(100 * TICKS_PER_US);
  localparam logic [12:0] T_300U = 13'(300 * TICKS_PER_US);
  localparam logic [12:0] T_1MS = 13'(1000 * TICKS_PER_US);
  localparam logic [12:0] SAMPLE_TICKS_RST = 13'h0008;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PRE = 5'b00010,
    ST_SENSE = 5'b00100,
    ST_SETTLE = 5'b01000,
    ST_SAMPLE = 5'b10000
  } tpt_state_t;
endpackage : tpt_pkg

// ===== tpt_touch_timing.sv
// Touch-panel detection and settling timing sequencer with its two registers
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Detection-disable bit at 0 runs pen detection, at 1 skips it, and it resets to 0.
// - A 3-bit code picks the precharge time, 0.25 us up to 1 ms at an 8 MHz timebase.
// - A 3-bit code picks the sense time, 1 us up to 1 ms at an 8 MHz timebase.
// - A 3-bit code picks the panel settling wait before each conversion, 0.25 us to 1 ms.
// - All intervals are fixed tick counts of the selected timebase, oscillator or divided clock.
// - A 2-bit field sets the comparator bias: normal, plus 25, 50 or 100 percent.
// - The sample-length bit at 1 doubles the sampling duration.
// - In self-controlled mode a detected pen touch starts conversions without a host command.
module tpt_touch_timing #(
  parameter logic [12:0] SAMPLE_TICKS = tpt_pkg::SAMPLE_TICKS_RST
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host control port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Timebase
  input wire logic timebase_sel,
  input wire logic osc_tick,
  input wire logic mclk_div_tick,
  // Conversion control
  input wire logic self_ctrl,
  input wire logic host_start,
  input wire logic [1:0] axis_count,
  input wire logic pen_sense,
  // Panel and converter controls
  output logic precharge_on,
  output logic sense_on,
  output logic settle_on,
  output logic sample_on,
  output logic pen_touch_q,
  output logic conv_done_q,
  output logic [1:0] bias_q
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] detect_timing_q;
  logic [7:0] settle_bias_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      detect_timing_q <= tpt_pkg::DETECT_TIMING_RST;
      settle_bias_q <= tpt_pkg::SETTLE_BIAS_RST;
    end else if (reg_wr) begin
      // Reserved bits are stored as written; software keeps them zero
      if (reg_addr == tpt_pkg::DETECT_TIMING_OFS) detect_timing_q <= reg_wdata;
      if (reg_addr == tpt_pkg::SETTLE_BIAS_OFS) settle_bias_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      unique case (reg_addr)
        tpt_pkg::DETECT_TIMING_OFS: reg_rdata_q <= detect_timing_q;
        tpt_pkg::SETTLE_BIAS_OFS: reg_rdata_q <= settle_bias_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) bias_q <= 2'b00;
    else bias_q <= settle_bias_q[tpt_pkg::BIAS_LSB +: 2];
  end

  // ----------------------------------------
  // Interval decode
  // ----------------------------------------
  // Sense table differs from the other two only in its two shortest codes
  function automatic logic [12:0] interval_ticks(input logic [2:0] code, input logic is_sense);
    logic [12:0] t;
    t = 13'h0000;
    unique case (code)
      3'h0: t = is_sense ? tpt_pkg::T_1U : tpt_pkg::T_0U25;
      3'h1: t = is_sense ? tpt_pkg::T_2U : tpt_pkg::T_1U;
      3'h2: t = tpt_pkg::T_3U;
      3'h3: t = tpt_pkg::T_10U;
      3'h4: t = tpt_pkg::T_30U;
      3'h5: t = tpt_pkg::T_100U;
      3'h6: t = tpt_pkg::T_300U;
      3'h7: t = tpt_pkg::T_1MS;
    endcase
    return t;
  endfunction : interval_ticks

  logic det_dis;
  logic [12:0] pre_ticks;
  logic [12:0] sense_ticks;
  logic [12:0] settle_ticks;
  logic [12:0] sample_ticks;
  assign det_dis = detect_timing_q[tpt_pkg::DET_DIS_BIT];
  assign pre_ticks = interval_ticks(detect_timing_q[tpt_pkg::PRE_LSB +: 3], 1'b0);
  assign sense_ticks = interval_ticks(detect_timing_q[tpt_pkg::SENSE_LSB +: 3], 1'b1);
  assign settle_ticks = interval_ticks(settle_bias_q[tpt_pkg::SETTLE_LSB +: 3], 1'b0);
  assign sample_ticks = settle_bias_q[tpt_pkg::SAMPLE_DBL_BIT] ?
                        13'(SAMPLE_TICKS << 1) : SAMPLE_TICKS;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  tpt_pkg::tpt_state_t state_q;
  tpt_pkg::tpt_state_t state_d;
  logic [12:0] cnt_q;
  logic [1:0] axis_q;
  logic tick;
  logic [12:0] cur_ticks;
  logic expire;

  // Real time scales with the chosen source frequency
  assign tick = timebase_sel ? osc_tick : mclk_div_tick;

  always_comb begin
    cur_ticks = 13'h0001;
    unique case (state_q)
      tpt_pkg::ST_PRE: cur_ticks = pre_ticks;
      tpt_pkg::ST_SENSE: cur_ticks = sense_ticks;
      tpt_pkg::ST_SETTLE: cur_ticks = settle_ticks;
      tpt_pkg::ST_SAMPLE: cur_ticks = sample_ticks;
      default: cur_ticks = 13'h0001;
    endcase
  end

  assign expire = tick && (cnt_q == 13'(cur_ticks - 13'h0001));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tpt_pkg::ST_IDLE: begin
        if (!det_dis && (self_ctrl || host_start)) state_d = tpt_pkg::ST_PRE;
        else if (det_dis && host_start && !self_ctrl) state_d = tpt_pkg::ST_SETTLE;
      end
      tpt_pkg::ST_PRE: if (expire) state_d = tpt_pkg::ST_SENSE;
      tpt_pkg::ST_SENSE: begin
        if (expire) begin
          if (pen_sense) state_d = tpt_pkg::ST_SETTLE;
          else state_d = tpt_pkg::ST_IDLE;
        end
      end
      tpt_pkg::ST_SETTLE: if (expire) state_d = tpt_pkg::ST_SAMPLE;
      tpt_pkg::ST_SAMPLE: begin
        if (expire) state_d = (axis_q != 2'b00) ? tpt_pkg::ST_SETTLE : tpt_pkg::ST_IDLE;
      end
      default: state_d = tpt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) state_q <= tpt_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge core_clk) begin
    if (rst || state_d != state_q) cnt_q <= 13'h0000;
    else if (tick) cnt_q <= 13'(cnt_q + 13'h0001);
  end

  // Axes still to convert after the current one
  always_ff @(posedge core_clk) begin
    if (rst) axis_q <= 2'b00;
    else if (state_q != tpt_pkg::ST_SETTLE && state_d == tpt_pkg::ST_SETTLE &&
             state_q != tpt_pkg::ST_SAMPLE) axis_q <= axis_count;
    else if (state_q == tpt_pkg::ST_SAMPLE && expire && axis_q != 2'b00)
      axis_q <= 2'(axis_q - 2'b01);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pen_touch_q <= 1'b0;
      conv_done_q <= 1'b0;
    end else begin
      if (state_q == tpt_pkg::ST_SENSE && expire) pen_touch_q <= pen_sense;
      conv_done_q <= state_q == tpt_pkg::ST_SAMPLE && state_d == tpt_pkg::ST_IDLE;
    end
  end

  // Outputs are the one-hot state flops themselves
  assign precharge_on = state_q[1];
  assign sense_on = state_q[2];
  assign settle_on = state_q[3];
  assign sample_on = state_q[4];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Watches the phase output itself, not the next-state decode that drives it
  property p_skip_detect;
    det_dis && !precharge_on |=> !precharge_on;
  endproperty
  a_skip_detect: assert property (p_skip_detect) else $error("detection ran while disabled");

  property p_pre_len;
    precharge_on && tick && cnt_q == 13'(pre_ticks - 13'h0001) |=> sense_on;
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("precharge length wrong");

  property p_sense_len;
    sense_on && tick && cnt_q == 13'(sense_ticks - 13'h0001) |=> !sense_on;
  endproperty
  a_sense_len: assert property (p_sense_len) else $error("sense length wrong");

  property p_settle_len;
    settle_on && tick && cnt_q == 13'(settle_ticks - 13'h0001) |=> sample_on;
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

  property p_no_tick_hold;
    (state_q != tpt_pkg::ST_IDLE) && !tick |=> $stable(state_q) && $stable(cnt_q);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("moved without a tick");

  property p_bias;
    reg_wr && reg_addr == tpt_pkg::SETTLE_BIAS_OFS |=> ##1 bias_q == $past(reg_wdata[7:6], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias not applied");

  property p_sample_dbl;
    sample_on && settle_bias_q[tpt_pkg::SAMPLE_DBL_BIT] && tick &&
      cnt_q == 13'(SAMPLE_TICKS - 13'h0001) |-> !expire;
  endproperty
  a_sample_dbl: assert property (p_sample_dbl) else $error("sample not doubled");

  property p_self_start;
    sense_on && expire && pen_sense |=> settle_on ##0 pen_touch_q;
  endproperty
  a_self_start: assert property (p_self_start) else $error("pen touch did not start");

  property p_pre_then_sense;
    $rose(sense_on) |-> $past(precharge_on);
  endproperty
  a_pre_then_sense: assert property (p_pre_then_sense) else $error("sense without precharge");

  c_detect_no_pen: cover property (sense_on && expire && !pen_sense);
  c_pen_convert: cover property (conv_done_q && pen_touch_q);
  c_host_skip: cover property (det_dis && settle_on);
  c_multi_axis: cover property (sample_on && expire && axis_q != 2'b00);
endmodule : tpt_touch_timing
`default_nettype wire

// ===== tpt_panel_model.sv
// Panel model: pen comparator seen by the touch timing block
`timescale 1ns/10ps
`default_nettype none
module tpt_panel_model (
  // Clock
  input wire logic core_clk,
  // Panel state
  input wire logic sense_on,
  input wire logic pen_present,
  output logic pen_sense
);
  logic junk_q = 1'b0;
  // Comparator wanders outside sensing, so a stale level never looks valid
  always @(posedge core_clk) begin
    junk_q <= ~junk_q;
  end
  assign pen_sense = sense_on ? pen_present : junk_q;
endmodule : tpt_panel_model
`default_nettype wire

// ===== tpt_touch_timing_tb_top.sv
// Testbench: registers and phase timing of the touch timing block
`timescale 1ns/10ps
`default_nettype none
module tpt_touch_timing_tb_top;
  // ----
  // Signals
  // ----
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic timebase_sel = 1'b1;
  logic osc_tick = 1'b1;
  logic mclk_div_tick = 1'b0;
  logic mclk_en = 1'b0;
  logic tick_half = 1'b0;
  logic self_ctrl = 1'b0;
  logic host_start = 1'b0;
  logic [1:0] axis_count = 2'h0;
  logic pen_present = 1'b1;
  logic pen_sense, precharge_on, sense_on, settle_on, sample_on, pen_touch_q, conv_done_q;
  logic [7:0] reg_rdata_q;
  logic [1:0] bias_q;
  int err_count = 0;
  int compares = 0;
  int n_pre, n_sen, n_set, n_smp, n_done;
  localparam int SMP = 2;
  localparam int PRE_T [8] = '{2, 8, 24, 80, 240, 800, 2400, 8000};
  localparam int SEN_T [8] = '{8, 16, 24, 80, 240, 800, 2400, 8000};

  always #25 core_clk = ~core_clk;

  // Divided-clock ticks: every cycle, or every other cycle in half-rate mode
  always @(posedge core_clk) begin
    mclk_div_tick <= mclk_en & (~tick_half | ~mclk_div_tick);
  end

  tpt_touch_timing #(.SAMPLE_TICKS(13'h0002)) tpt_touch_timing_inst (
    .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .timebase_sel(timebase_sel),
    .osc_tick(osc_tick), .mclk_div_tick(mclk_div_tick), .self_ctrl(self_ctrl),
    .host_start(host_start), .axis_count(axis_count), .pen_sense(pen_sense),
    .precharge_on(precharge_on), .sense_on(sense_on), .settle_on(settle_on),
    .sample_on(sample_on), .pen_touch_q(pen_touch_q), .conv_done_q(conv_done_q),
    .bias_q(bias_q));
  tpt_panel_model tpt_panel_model_inst (
    .core_clk(core_clk), .sense_on(sense_on), .pen_present(pen_present),
    .pen_sense(pen_sense));

  // ----
  // Shared tasks
  // ----
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Reserved bits are always written as zero by every caller
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    #1;
    chk("rdata", 16'(exp), 16'(reg_rdata_q));
  endtask : rd

  // Counts cycles of each phase until the sequencer has sat idle a while
  task automatic run(input logic hs, input logic sc, input logic [1:0] ax);
    int idle = 0;
    bit seen = 0;
    n_pre = 0;
    n_sen = 0;
    n_set = 0;
    n_smp = 0;
    n_done = 0;
    @(posedge core_clk);
    host_start <= hs;
    self_ctrl <= sc;
    axis_count <= ax;
    for (int i = 0; i < 30000; i++) begin
      @(posedge core_clk);
      host_start <= 1'b0;
      self_ctrl <= 1'b0;
      #1;
      n_pre += int'(precharge_on === 1'b1);
      n_sen += int'(sense_on === 1'b1);
      n_set += int'(settle_on === 1'b1);
      n_smp += int'(sample_on === 1'b1);
      n_done += int'(conv_done_q === 1'b1);
      idle = ((precharge_on | sense_on | settle_on | sample_on) === 1'b0) ? idle + 1 : 0;
      seen = seen || idle == 0;
      if (seen && idle > 3) return;
    end
    chk("timeout", 16'h0000, 16'h0001);
    print_verdict();
  endtask : run

  task automatic exp5(input int p, input int s, input int t, input int m, input int d);
    chk("precharge", 16'(p), 16'(n_pre));
    chk("sense", 16'(s), 16'(n_sen));
    chk("settle", 16'(t), 16'(n_set));
    chk("sample", 16'(m), 16'(n_smp));
    chk("done", 16'(d), 16'(n_done));
  endtask : exp5

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    chk("bias", 16'h0000, 16'(bias_q));
  endtask : t_reset

  task automatic t_bias();
    for (int b = 3; b >= 0; b--) begin
      wr(8'h05, {2'(b), 6'h00});
      repeat (2) @(posedge core_clk);
      #1;
      chk("bias", 16'(b), 16'(bias_q));
      rd(8'h05, {2'(b), 6'h00});
    end
  endtask : t_bias

  // Every code of all three intervals, longest last
  task automatic t_codes();
    for (int k = 0; k < 8; k++) begin
      wr(8'h04, {1'b0, 3'(k), 1'b0, 3'(k)});
      wr(8'h05, {5'h00, 3'(k)});
      run(1'b1, 1'b0, 2'h0);
      exp5(PRE_T[k], SEN_T[k], PRE_T[k], SMP, 1);
    end
  endtask : t_codes

  task automatic t_modes();
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h20);
    run(1'b1, 1'b0, 2'h1);
    exp5(2, 8, 4, 4 * SMP, 1);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h80);
    run(1'b1, 1'b0, 2'h0);
    exp5(0, 0, 2, SMP, 1);
    wr(8'h04, 8'h00);
    pen_present <= 1'b0;
    run(1'b1, 1'b0, 2'h0);
    exp5(2, 8, 0, 0, 0);
    chk("pen", 16'h0000, 16'(pen_touch_q));
    // Flag starts from a miss, so only the self-started run can raise it
    @(posedge core_clk);
    pen_present <= 1'b1;
    run(1'b0, 1'b1, 2'h0);
    exp5(2, 8, 2, SMP, 1);
    chk("pen", 16'h0001, 16'(pen_touch_q));
    // Only the divided clock ticks, so the oscillator must be ignored
    @(posedge core_clk);
    timebase_sel <= 1'b0;
    osc_tick <= 1'b0;
    mclk_en <= 1'b1;
    run(1'b1, 1'b0, 2'h0);
    exp5(2, 8, 2, SMP, 1);
    // Half-rate ticks: phases count ticks, not cycles; first phase depends on alignment
    @(posedge core_clk);
    tick_half <= 1'b1;
    run(1'b1, 1'b0, 2'h2);
    chk("slow precharge", 16'h0001, 16'(n_pre inside {3, 4}));
    chk("slow sense", 16'h0010, 16'(n_sen));
    chk("slow settle", 16'h000c, 16'(n_set));
    chk("slow sample", 16'h000c, 16'(n_smp));
    chk("slow done", 16'h0001, 16'(n_done));
  endtask : t_modes

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_bias();
    t_codes();
    t_modes();
    print_verdict();
  end
endmodule : tpt_touch_timing_tb_top
`default_nettype wire
